// ---- rtl/addr_assign_lock.v ----
// addr_assign_lock.v: target-side address configuration and
// commissioning command set of a digitally controlled power module.
// assumes: a serial front end delivers each decoded transaction as a
// one-cycle txn_valid pulse synchronous to ref_clk.
`timescale 1ns/1ps
`include "addr_cfg_defs.vh"

module addr_assign_lock (
  input  wire        ref_clk,       // 10 mhz system clock
  input  wire        reset_n,       // asynchronous reset, active low
  input  wire        txn_valid,     // one-cycle decoded transaction
  input  wire        txn_via_i2c,   // 1: i2c interface, 0: pmbus
  input  wire [6:0]  txn_target,    // target address of transaction
  input  wire        txn_write,     // 1: write, 0: read
  input  wire [7:0]  txn_code,      // command code
  input  wire [15:0] txn_reg_index, // internal index for command d0
  input  wire [15:0] txn_wdata,     // write data, low bits for bytes
  input  wire        test_mode,     // test mode level
  output reg         rsp_ack,       // pulse: transaction accepted
  output reg         rsp_nak,       // pulse: addressed, not accepted
  output reg  [15:0] rsp_rdata,     // read data, valid with rsp_ack
  output reg  [6:0]  i2c_addr_r,    // current i2c target address
  output reg  [6:0]  pmb_addr_r,    // current pmbus target address
  output reg         addr_lock_r,   // address lock state
  output reg  [7:0]  page_r,        // selected page
  output reg  [15:0] vout_cmd_r,    // output voltage setting
  output reg  [7:0]  ov_resp_r,     // over-voltage fault response
  output reg  [15:0] ov_lim_r,      // over-voltage fault limit
  output reg  [15:0] ov_warn_r,     // over-voltage warning limit
  output reg  [7:0]  on_off_cfg_r,  // on/off configuration
  output reg         nvm_store      // pulse: commit config to nvm
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // read view of an internal register behind the indirect command
  function [15:0] indirect_view;
    input [15:0] idx;
    input [6:0]  i2c_a;
    input [6:0]  pmb_a;
    input        lock;
    begin
      indirect_view = 16'h0000;
      if (idx == `IDX_TARGET_ADDR) begin
        indirect_view[`I2C_ADDR_MSB:`I2C_ADDR_LSB] = i2c_a;
        indirect_view[`PMB_ADDR_MSB:`PMB_ADDR_LSB] = pmb_a;
      end else if (idx == `IDX_ADDR_PROTECT) begin
        indirect_view[`LOCK_BIT] = lock;
      end
    end
  endfunction

  // ****************************************************************
  // addressing
  // ****************************************************************
  wire hit;

  target_addr_match u_match (
    .via_i2c   (txn_via_i2c),
    .target    (txn_target),
    .i2c_addr  (i2c_addr_r),
    .pmb_addr  (pmb_addr_r),
    .test_mode (test_mode),
    .hit       (hit)
  );

  // ****************************************************************
  // next-state decode
  // ****************************************************************
  reg        rsp_ack_nxt;
  reg        rsp_nak_nxt;
  reg [15:0] rsp_rdata_nxt;
  reg [6:0]  i2c_addr_nxt;
  reg [6:0]  pmb_addr_nxt;
  reg        addr_lock_nxt;
  reg [7:0]  page_nxt;
  reg [15:0] vout_cmd_nxt;
  reg [7:0]  ov_resp_nxt;
  reg [15:0] ov_lim_nxt;
  reg [15:0] ov_warn_nxt;
  reg [7:0]  on_off_cfg_nxt;
  reg        nvm_store_nxt;
  reg        page_ok;
  reg        do_wr;

  // command decode for one addressed transaction
  always @* begin
    rsp_ack_nxt    = 1'b0;
    rsp_nak_nxt    = 1'b0;
    rsp_rdata_nxt  = 16'h0000;
    i2c_addr_nxt   = i2c_addr_r;
    pmb_addr_nxt   = pmb_addr_r;
    addr_lock_nxt  = addr_lock_r;
    page_nxt       = page_r;
    vout_cmd_nxt   = vout_cmd_r;
    ov_resp_nxt    = ov_resp_r;
    ov_lim_nxt     = ov_lim_r;
    ov_warn_nxt    = ov_warn_r;
    on_off_cfg_nxt = on_off_cfg_r;
    nvm_store_nxt  = 1'b0;
    page_ok        = (page_r == `PAGE_ZERO);
    do_wr          = txn_valid && hit && txn_write;
    if (txn_valid && hit) begin
      rsp_ack_nxt = 1'b1;
      case (txn_code)
        `CMD_PAGE: begin
          rsp_rdata_nxt = {8'h00, page_r};
          if (do_wr) begin
            if (txn_wdata[7:0] == `PAGE_ZERO)
              page_nxt = txn_wdata[7:0];
            else begin
              rsp_ack_nxt = 1'b0;
              rsp_nak_nxt = 1'b1;
            end
          end
        end
        `CMD_VOUT_COMMAND: begin
          rsp_rdata_nxt = vout_cmd_r;
          if (do_wr && page_ok)
            vout_cmd_nxt = txn_wdata;
        end
        `CMD_OV_FAULT_RESP: begin
          rsp_rdata_nxt = {8'h00, ov_resp_r};
          if (do_wr && page_ok)
            ov_resp_nxt = txn_wdata[7:0];
        end
        `CMD_OV_FAULT_LIM: begin
          rsp_rdata_nxt = ov_lim_r;
          if (do_wr && page_ok)
            ov_lim_nxt = txn_wdata;
        end
        `CMD_OV_WARN_LIM: begin
          rsp_rdata_nxt = ov_warn_r;
          if (do_wr && page_ok)
            ov_warn_nxt = txn_wdata;
        end
        `CMD_ON_OFF_CONFIG: begin
          rsp_rdata_nxt = {8'h00, on_off_cfg_r};
          if (do_wr)
            on_off_cfg_nxt = txn_wdata[7:0];
        end
        `CMD_STORE_ALL: begin
          // send-byte: a write commits, a read is refused
          if (do_wr)
            nvm_store_nxt = 1'b1;
          else begin
            rsp_ack_nxt = 1'b0;
            rsp_nak_nxt = 1'b1;
          end
        end
        `CMD_INDIRECT_REG: begin
          rsp_rdata_nxt = indirect_view(txn_reg_index, i2c_addr_r,
                                        pmb_addr_r, addr_lock_r);
          if (do_wr) begin
            if (txn_reg_index == `IDX_TARGET_ADDR) begin
              // locked fields keep their value, write still acked
              if (!addr_lock_r) begin
                i2c_addr_nxt =
                  txn_wdata[`I2C_ADDR_MSB:`I2C_ADDR_LSB];
                pmb_addr_nxt =
                  txn_wdata[`PMB_ADDR_MSB:`PMB_ADDR_LSB];
              end
            end else if (txn_reg_index == `IDX_ADDR_PROTECT) begin
              addr_lock_nxt = txn_wdata[`LOCK_BIT];
            end
          end
        end
        default: begin
          rsp_ack_nxt = 1'b0;
          rsp_nak_nxt = 1'b1;
        end
      endcase
    end
  end

  // ****************************************************************
  // state registers
  // ****************************************************************

  // all outputs registered; defaults give the unconfigured addresses
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_ack      <= 1'b0;
      rsp_nak      <= 1'b0;
      rsp_rdata    <= 16'h0000;
      i2c_addr_r   <= `I2C_ADDR_RESET;
      pmb_addr_r   <= `PMB_ADDR_RESET;
      addr_lock_r  <= `LOCK_RESET;
      page_r       <= `PAGE_ZERO;
      vout_cmd_r   <= `VOUT_CMD_RESET;
      ov_resp_r    <= `OV_RESP_RESET;
      ov_lim_r     <= `OV_LIM_RESET;
      ov_warn_r    <= `OV_WARN_RESET;
      on_off_cfg_r <= `ON_OFF_RESET;
      nvm_store    <= 1'b0;
    end else begin
      rsp_ack      <= rsp_ack_nxt;
      rsp_nak      <= rsp_nak_nxt;
      rsp_rdata    <= rsp_rdata_nxt;
      i2c_addr_r   <= i2c_addr_nxt;
      pmb_addr_r   <= pmb_addr_nxt;
      addr_lock_r  <= addr_lock_nxt;
      page_r       <= page_nxt;
      vout_cmd_r   <= vout_cmd_nxt;
      ov_resp_r    <= ov_resp_nxt;
      ov_lim_r     <= ov_lim_nxt;
      ov_warn_r    <= ov_warn_nxt;
      on_off_cfg_r <= on_off_cfg_nxt;
      nvm_store    <= nvm_store_nxt;
    end
  end

endmodule

// ---- rtl/addr_cfg_defs.vh ----
// addr_cfg_defs.vh: command codes, internal register indexes, field
// positions and reset values of the address configuration block.
// assumes: included by bare name from the design files under rtl/.
`ifndef ADDR_CFG_DEFS_VH
`define ADDR_CFG_DEFS_VH

// ****************************************************************
// command codes
// ****************************************************************
`define CMD_PAGE          8'h00
`define CMD_ON_OFF_CONFIG 8'h02
`define CMD_STORE_ALL     8'h15
`define CMD_VOUT_COMMAND  8'h21
`define CMD_OV_FAULT_LIM  8'h40
`define CMD_OV_FAULT_RESP 8'h41
`define CMD_OV_WARN_LIM   8'h42
`define CMD_INDIRECT_REG  8'hd0

// ****************************************************************
// internal registers reached through the indirect command
// ****************************************************************
`define IDX_TARGET_ADDR   16'h0020
`define IDX_ADDR_PROTECT  16'h0094
`define I2C_ADDR_MSB      14
`define I2C_ADDR_LSB      8
`define PMB_ADDR_MSB      6
`define PMB_ADDR_LSB      0
`define LOCK_BIT          2

// ****************************************************************
// reset values and fixed addresses
// ****************************************************************
`define I2C_ADDR_RESET    7'h10
`define PMB_ADDR_RESET    7'h40
`define I2C_TEST_ADDR     7'h14
`define LOCK_RESET        1'b0
`define PAGE_ZERO         8'h00
`define VOUT_CMD_RESET    16'h0000
`define OV_LIM_RESET      16'h0000
`define OV_RESP_RESET     8'h00
`define OV_WARN_RESET     16'h0000
`define ON_OFF_RESET      8'h00

`endif

// ---- rtl/target_addr_match.v ----
// target_addr_match.v: decides whether a transaction is addressed to
// this unit on the interface it arrived on.
// assumes: addresses are stable register values; purely combinational.
`timescale 1ns/1ps
`include "addr_cfg_defs.vh"

module target_addr_match (
  input  wire       via_i2c,   // 1: arrived on i2c, 0: on pmbus
  input  wire [6:0] target,    // target address of the transaction
  input  wire [6:0] i2c_addr,  // programmed i2c address
  input  wire [6:0] pmb_addr,  // programmed pmbus address
  input  wire       test_mode, // test mode strap level
  output wire       hit        // transaction is for this unit
);

  // ****************************************************************
  // address compare
  // ****************************************************************
  wire i2c_hit;
  wire pmb_hit;

  // zero field disables the i2c side; test address added in test mode
  assign i2c_hit = ((i2c_addr != 7'h00) &&
                    (target == i2c_addr)) ||
                   (test_mode && (target == `I2C_TEST_ADDR));
  // zero field disables the pmbus side
  assign pmb_hit = (pmb_addr != 7'h00) && (target == pmb_addr);
  assign hit     = via_i2c ? i2c_hit : pmb_hit;

endmodule

// ---- sim/addr_assign_lock_properties.sv ----
// addr_assign_lock_properties.sv: port assertions for the address block.
// assumes: bound to addr_assign_lock, one ref_clk domain.
`timescale 1ns/1ps
`include "addr_cfg_defs.vh"

module addr_lock_checker (
  input wire        ref_clk,       // clock
  input wire        reset_n,       // reset, low
  input wire        txn_valid,     // request
  input wire        txn_via_i2c,   // i2c side
  input wire [6:0]  txn_target,    // address
  input wire        txn_write,     // write
  input wire [7:0]  txn_code,      // command
  input wire [15:0] txn_reg_index, // index
  input wire [15:0] txn_wdata,     // data
  input wire        test_mode,     // test level
  input wire        rsp_ack,       // accept
  input wire        rsp_nak,       // refuse
  input wire [6:0]  i2c_addr_r,    // i2c address
  input wire [6:0]  pmb_addr_r,    // pmbus address
  input wire        addr_lock_r,   // lock
  input wire [7:0]  page_r,        // page
  input wire [15:0] vout_cmd_r,    // voltage
  input wire        nvm_store      // commit
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // address match and decoded writes
  wire tst = test_mode && txn_target == `I2C_TEST_ADDR;
  wire hi2 = (i2c_addr_r != 7'h00 && txn_target == i2c_addr_r) || tst;
  wire hpm = pmb_addr_r != 7'h00 && txn_target == pmb_addr_r;
  wire hit = txn_valid && (txn_via_i2c ? hi2 : hpm);
  wire wd0 = hit && txn_write && txn_code == `CMD_INDIRECT_REG;
  wire any = rsp_ack || rsp_nak;

  sequence store_req;
    hit && txn_write && txn_code == `CMD_STORE_ALL;
  endsequence
  sequence store_done;
    rsp_ack && nvm_store ##1 !nvm_store;
  endsequence

  a_reset_addr: assert property (
    $rose(reset_n) |-> i2c_addr_r == `I2C_ADDR_RESET &&
    pmb_addr_r == `PMB_ADDR_RESET && !addr_lock_r)
    else $error("reset address");
  a_i2c_off: assert property (
    txn_valid && txn_via_i2c && i2c_addr_r == 7'h00 && !tst |=> !any)
    else $error("i2c answered at zero");
  a_pmb_off: assert property (txn_valid && !txn_via_i2c
    && pmb_addr_r == 0 |=> !any) else $error("pmbus answered at zero");
  a_test_addr: assert property (txn_valid && txn_via_i2c && tst
    |=> any) else $error("test address ignored");
  a_addr_set: assert property (
    wd0 && !addr_lock_r && txn_reg_index == `IDX_TARGET_ADDR |=>
    i2c_addr_r == $past(txn_wdata[14:8]) &&
    pmb_addr_r == $past(txn_wdata[6:0])) else $error("address write lost");
  a_lock_guard: assert property (
    wd0 && addr_lock_r && txn_reg_index == `IDX_TARGET_ADDR |=>
    $stable(i2c_addr_r) && $stable(pmb_addr_r)) else $error("locked write");
  a_lock_set: assert property (wd0 && txn_reg_index == 16'h0094
    |=> addr_lock_r == $past(txn_wdata[2])) else $error("lock bit");
  a_vout_write: assert property (
    hit && txn_write && page_r == 8'h00 && txn_code == `CMD_VOUT_COMMAND
    |=> vout_cmd_r == $past(txn_wdata)) else $error("vout write");
  a_store_commit: assert property (store_req |=> store_done)
    else $error("store pulse");
endmodule

bind addr_assign_lock addr_lock_checker chk_i (.ref_clk, .reset_n,
  .txn_valid, .txn_via_i2c, .txn_target, .txn_write, .txn_code,
  .txn_reg_index, .txn_wdata, .test_mode, .rsp_ack, .rsp_nak,
  .i2c_addr_r, .pmb_addr_r, .addr_lock_r, .page_r, .vout_cmd_r,
  .nvm_store);

// ---- sim/pmbus_host_model.sv ----
// pmbus_host_model.sv: host issuing decoded transactions one at a time.
// assumes: drives on falling ref_clk edges, answer one cycle later.
`timescale 1ns/1ps

module pmbus_host_model (
  input  wire        ref_clk,       // clock
  input  wire        rsp_ack,       // accept
  input  wire        rsp_nak,       // refuse
  input  wire [15:0] rsp_rdata,     // read data
  output reg         txn_valid,     // request
  output reg         txn_via_i2c,   // i2c side
  output reg  [6:0]  txn_target,    // address
  output reg         txn_write,     // write
  output reg  [7:0]  txn_code,      // command
  output reg  [15:0] txn_reg_index, // index
  output reg  [15:0] txn_wdata      // data
);
  reg [1:0]  resp; // nak, ack
  reg [15:0] rd;   // captured read data

  // idle bus at time zero
  initial begin
    {txn_valid, txn_via_i2c, txn_target, txn_write} = 10'h000;
    {txn_code, txn_reg_index, txn_wdata} = 40'h0;
  end

  // one request, answer sampled, target, code and data lines inverted on release
  task send(input v, input [6:0] t, input w, input [7:0] c,
            input [15:0] i, input [15:0] d);
    @(negedge ref_clk);
    {txn_valid, txn_via_i2c, txn_target, txn_write} = {1'b1, v, t, w};
    {txn_code, txn_reg_index, txn_wdata} = {c, i, d};
    @(negedge ref_clk);
    resp = {rsp_nak, rsp_ack};
    rd = rsp_rdata;
    txn_valid = 1'b0;
    {txn_target, txn_code, txn_wdata} = ~{txn_target, txn_code, txn_wdata};
  endtask
endmodule

// ---- sim/test_addr_assign_lock.sv ----
// test_addr_assign_lock.sv: self-checking bench for the address block.
// assumes: host model drives requests, 100 ns clock.
`timescale 1ns/1ps
`include "addr_cfg_defs.vh"

module test_addr_assign_lock;
  reg ref_clk, reset_n, test_mode;
  wire txn_valid, txn_via_i2c, txn_write, rsp_ack, rsp_nak;
  wire nvm_store, addr_lock_r;
  wire [6:0]  txn_target, i2c_addr_r, pmb_addr_r;
  wire [7:0]  txn_code, page_r, ov_resp_r, on_off_cfg_r;
  wire [15:0] txn_reg_index, txn_wdata, rsp_rdata;
  wire [15:0] vout_cmd_r, ov_lim_r, ov_warn_r;
  integer mismatches, comparisons;

  // clock
  always #50 ref_clk = ~ref_clk;

  pmbus_host_model host (.ref_clk, .rsp_ack, .rsp_nak, .rsp_rdata,
    .txn_valid, .txn_via_i2c, .txn_target, .txn_write, .txn_code,
    .txn_reg_index, .txn_wdata);
  addr_assign_lock uut (.ref_clk, .reset_n, .txn_valid, .txn_via_i2c,
    .txn_target, .txn_write, .txn_code, .txn_reg_index, .txn_wdata,
    .test_mode, .rsp_ack, .rsp_nak, .rsp_rdata, .i2c_addr_r, .pmb_addr_r,
    .addr_lock_r, .page_r, .vout_cmd_r, .ov_resp_r, .ov_lim_r, .ov_warn_r,
    .on_off_cfg_r, .nvm_store);

  // value compare and response compare
  task chk(input [8*8:1] n, input [15:0] e, input [15:0] g);
    comparisons = comparisons + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("BAD %0s expected %h seen %h", n, e, g);
    end
  endtask
  task rsp(input [1:0] e);
    chk("response", {14'h0, e}, {14'h0, host.resp});
  endtask
  // write to the indirect register command
  task wd0(input v, input [6:0] t, input [15:0] i, input [15:0] d);
    host.send(v, t, 1'b1, `CMD_INDIRECT_REG, i, d);
  endtask

  // default addresses loaded after reset, i2c default answers
  task t_reset;
    chk("i2c", 16'h0010, {9'h0, i2c_addr_r});
    chk("pmb", 16'h0040, {9'h0, pmb_addr_r});
    host.send(1'b1, 7'h10, 1'b0, `CMD_INDIRECT_REG, 16'h0020, 16'h0);
    rsp(2'b01);
    chk("rdata", 16'h1040, host.rd);
  endtask
  // unique addresses given to the first unit powered; 0x12 not reserved
  task t_assign;
    wd0(1'b1, 7'h10, 16'h0020, 16'h1242);
    rsp(2'b01);
    chk("i2c", 16'h0012, {9'h0, i2c_addr_r});
    chk("pmb", 16'h0042, {9'h0, pmb_addr_r});
    host.send(1'b1, 7'h10, 1'b0, `CMD_INDIRECT_REG, 16'h0020, 16'h0);
    rsp(2'b00);
  endtask
  // lock freezes both address fields
  task t_lock;
    wd0(1'b0, 7'h42, 16'h0094, 16'h0004);
    chk("lock", 16'h0001, {15'h0, addr_lock_r});
    host.send(1'b0, 7'h42, 1'b0, `CMD_INDIRECT_REG, 16'h0094, 16'h0);
    chk("rdata", 16'h0004, host.rd);
    wd0(1'b0, 7'h42, 16'h0020, 16'h1141);
    chk("i2c", 16'h0012, {9'h0, i2c_addr_r});
    chk("pmb", 16'h0042, {9'h0, pmb_addr_r});
    wd0(1'b0, 7'h42, 16'h0094, 16'h0000);
    chk("lock", 16'h0000, {15'h0, addr_lock_r});
  endtask
  // commissioning commands then commit
  task t_cfg;
    host.send(1'b0, 7'h42, 1'b1, `CMD_PAGE, 16'h0, 16'h0000);
    host.send(1'b0, 7'h42, 1'b1, `CMD_VOUT_COMMAND, 16'h0, 16'h0123);
    chk("vout", 16'h0123, vout_cmd_r);
    host.send(1'b0, 7'h42, 1'b0, `CMD_VOUT_COMMAND, 16'h0, 16'h0);
    rsp(2'b01);
    chk("rdata", 16'h0123, host.rd);
    host.send(1'b0, 7'h42, 1'b1, `CMD_OV_FAULT_RESP, 16'h0, 16'h0080);
    chk("ovresp", 16'h0080, {8'h0, ov_resp_r});
    host.send(1'b0, 7'h42, 1'b1, `CMD_OV_FAULT_LIM, 16'h0, 16'h0234);
    chk("ovlim", 16'h0234, ov_lim_r);
    host.send(1'b0, 7'h42, 1'b1, `CMD_OV_WARN_LIM, 16'h0, 16'h0222);
    chk("ovwarn", 16'h0222, ov_warn_r);
    host.send(1'b0, 7'h42, 1'b1, `CMD_ON_OFF_CONFIG, 16'h0, 16'h0018);
    chk("onoff", 16'h0018, {8'h0, on_off_cfg_r});
    host.send(1'b0, 7'h42, 1'b1, `CMD_PAGE, 16'h0, 16'h0001);
    rsp(2'b10);
    chk("page", 16'h0000, {8'h0, page_r});
    host.send(1'b0, 7'h42, 1'b0, `CMD_STORE_ALL, 16'h0, 16'h0);
    rsp(2'b10);
    chk("store", 16'h0000, {15'h0, nvm_store});
    host.send(1'b0, 7'h42, 1'b1, `CMD_STORE_ALL, 16'h0, 16'h0);
    chk("store", 16'h0001, {15'h0, nvm_store});
    @(negedge ref_clk);
    chk("store", 16'h0000, {15'h0, nvm_store});
  endtask
  // zero address disables, test address still answers
  task t_disable;
    wd0(1'b0, 7'h42, 16'h0020, 16'h0042);
    host.send(1'b1, 7'h00, 1'b0, `CMD_PAGE, 16'h0, 16'h0);
    rsp(2'b00);
    test_mode = 1'b1;
    wd0(1'b1, 7'h14, 16'h0020, 16'h1200);
    rsp(2'b01);
    host.send(1'b0, 7'h00, 1'b0, `CMD_PAGE, 16'h0, 16'h0);
    rsp(2'b00);
    test_mode = 1'b0;
    wd0(1'b1, 7'h12, 16'h0020, 16'h1242);
    chk("pmb", 16'h0042, {9'h0, pmb_addr_r});
  endtask

  // verdict
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (3000) @(posedge ref_clk);
    mismatches = mismatches + 1;
    finish_test;
  end

  // main sequence, second reset in mid-run
  initial begin
    {ref_clk, reset_n, test_mode} = 3'b000;
    mismatches = 0;
    comparisons = 0;
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    t_reset;
    t_assign;
    t_lock;
    t_cfg;
    t_disable;
    @(negedge ref_clk);
    reset_n = 1'b0;
    @(negedge ref_clk);
    reset_n = 1'b1;
    t_reset;
    finish_test;
  end
endmodule
